// ==== rtl/dac_core.sv ====
// Device-side command decode, burst sequencing and error alert pin logic.
//
// Function
// [R01] A write CRC error drives the alert pin low for a fixed interval then releases it high.
// [R02] A command/address parity error holds the alert pin low until internal recovery ends.
// [R03] During connectivity test the alert pin is an input, not an error output.
// [R04] Test mode follows the test enable input; the controller keeps it low in normal use.
// [R05] The array has eight banks in two groups of four.
// [R06] Each access moves one 8n-bit core word over four clocks as eight half-clock beats; the sequencer here steps one beat per clock.
// [R07] Bursts start at the selected column and run eight beats, or four when chopped.
// [R08] The controller opens a row with an activate before reading or writing that bank.
// [R09] Activate takes bank group, bank and row A0-A14 from the inputs.
// [R10] Read and write take the start column from the address and A10 decides auto-precharge.
// [R11] With on-the-fly selection enabled, A12 chooses a four or eight beat burst.
// [R12] The controller completes initialization before normal traffic.
// [R13] A10 high means auto-precharge on access and all banks on precharge.
// [R14] The chop select bit high means no chop and low means a chopped burst.
// [R15] With no pending error and no test mode the alert pin rests high.
`timescale 1ns/100ps
module dac_core #(
   parameter int unsigned CRC_CYC = dac_pkg::CRC_ALERT_CYC,
   parameter int unsigned PAR_CYC = dac_pkg::PAR_ALERT_CYC
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire dac_pkg::dac_req_s req_i,
   input wire logic otf_enable_i,
   input wire logic chop_fixed_i,
   input wire logic crc_error_i,
   input wire logic parity_error_i,
   input wire logic conn_test_enable_i,
   input wire logic alert_n_i,
   output logic alert_n_o,
   output logic alert_n_oe_o,
   output logic test_alert_o,
   output logic test_mode_o,
   output logic [dac_pkg::BANKS-1:0] open_banks_o,
   output dac_pkg::dac_beat_s beat_o,
   output logic core_xfer_o,
   output logic misuse_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] bank_idx(input logic g, input logic [1:0] b);
      bank_idx = {g, b};
   endfunction

   function automatic logic is_chop(input logic otf, input logic fixed, input logic bit12);
      is_chop = otf ? !bit12 : fixed;
   endfunction

   // ----------------------------------------------------------------
   // Bank state
   // ----------------------------------------------------------------
   logic [dac_pkg::BANKS-1:0] open_q, open_d;
   logic [dac_pkg::ROW_W-1:0] row_q [dac_pkg::BANKS];
   logic [dac_pkg::ROW_W-1:0] row_d [dac_pkg::BANKS];
   logic misuse_q, misuse_d;
   logic pend_pre_q, pend_pre_d;
   logic [2:0] pend_bank_q, pend_bank_d;
   logic [2:0] sel;
   logic access;

   assign sel = bank_idx(req_i.group_select, req_i.bank_select);
   assign access = (req_i.cmd == dac_pkg::CMD_RD) || (req_i.cmd == dac_pkg::CMD_WR);

   logic burst_done;

   always_comb begin
      open_d = open_q;
      row_d = row_q;
      misuse_d = 1'b0;
      pend_pre_d = pend_pre_q;
      pend_bank_d = pend_bank_q;
      if (pend_pre_q && burst_done) begin
         open_d[pend_bank_q] = 1'b0; // R13
         pend_pre_d = 1'b0;
      end
      unique case (req_i.cmd)
         dac_pkg::CMD_ACT: begin
            open_d[sel] = 1'b1; // R09
            row_d[sel] = req_i.addr[dac_pkg::ROW_W-1:0]; // R09
         end
         dac_pkg::CMD_RD, dac_pkg::CMD_WR: begin
            misuse_d = !open_q[sel]; // R08
            if (open_q[sel] && req_i.addr[dac_pkg::PRE_BIT]) begin
               pend_pre_d = 1'b1; // R10
               pend_bank_d = sel;
            end
         end
         dac_pkg::CMD_PRE: begin
            if (req_i.addr[dac_pkg::PRE_BIT]) begin
               open_d = '0; // R13
            end else begin
               open_d[sel] = 1'b0; // R13
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         open_q <= '0;
         misuse_q <= 1'b0;
         pend_pre_q <= 1'b0;
         pend_bank_q <= 3'h0;
      end else begin
         open_q <= open_d;
         misuse_q <= misuse_d;
         pend_pre_q <= pend_pre_d;
         pend_bank_q <= pend_bank_d;
      end
   end

   // Eight banks, two groups of four, each holding its open row.
   for (genvar g = 0; g < dac_pkg::BANKS; g++) begin : g_row // R05
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            row_q[g] <= '0;
         end else begin
            row_q[g] <= row_d[g];
         end
      end
   end

   // ----------------------------------------------------------------
   // Burst sequencer
   // ----------------------------------------------------------------
   // A new access while a burst runs restarts it; spacing is the controller's job.
   dac_pkg::dac_beat_s beat_q, beat_d;
   logic [3:0] left_q, left_d;
   logic core_q, core_d;
   logic [2:0] clk_cnt_q, clk_cnt_d;

   assign burst_done = beat_q.valid && (left_q == 4'h1);

   always_comb begin
      beat_d = beat_q;
      left_d = left_q;
      core_d = 1'b0;
      clk_cnt_d = clk_cnt_q;
      if (beat_q.valid) begin
         beat_d.col = beat_q.col + 10'h001; // R07
         beat_d.beat = beat_q.beat + 4'h1;
         left_d = left_q - 4'h1;
         if (left_q == 4'h1) begin
            beat_d.valid = 1'b0;
         end
      end
      if (clk_cnt_q != 3'h0) begin
         clk_cnt_d = clk_cnt_q - 3'h1; // R06
         core_d = (clk_cnt_q == 3'h1);
      end
      if (access && open_q[sel]) begin
         beat_d.valid = 1'b1;
         beat_d.write = (req_i.cmd == dac_pkg::CMD_WR);
         beat_d.bank = sel;
         beat_d.row = row_q[sel];
         beat_d.col = req_i.addr[dac_pkg::COL_W-1:0]; // R10
         beat_d.beat = 4'h0;
         beat_d.auto_pre = req_i.addr[dac_pkg::PRE_BIT]; // R13
         // With on-the-fly selection, A12 high means full burst and low means chopped; otherwise chop_fixed_i high chops.
         left_d = is_chop(otf_enable_i, chop_fixed_i, req_i.addr[dac_pkg::CHOP_BIT]) ?
                  dac_pkg::BEATS_CHOP : dac_pkg::BEATS_FULL; // R11 R14
         clk_cnt_d = dac_pkg::CORE_CLOCKS; // R06
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         beat_q <= '0;
         left_q <= 4'h0;
         core_q <= 1'b0;
         clk_cnt_q <= 3'h0;
      end else begin
         beat_q <= beat_d;
         left_q <= left_d;
         core_q <= core_d;
         clk_cnt_q <= clk_cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // Alert pin
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      AL_IDLE = 4'h1,
      AL_CRC = 4'h2,
      AL_PAR = 4'h4,
      AL_TEST = 4'h8
   } dac_alert_e;

   dac_alert_e al_q, al_d;
   logic [7:0] al_cnt_q, al_cnt_d;
   logic alert_q, alert_d;
   logic oe_q, oe_d;
   logic tin_q, tin_d;
   logic tm_q, tm_d;

   // Parity outranks CRC because its recovery is longer and must not be cut short.
   always_comb begin
      al_d = al_q;
      al_cnt_d = al_cnt_q;
      tm_d = conn_test_enable_i; // R04
      tin_d = tin_q;
      if (conn_test_enable_i) begin
         al_d = AL_TEST; // R03
      end else begin
         unique case (al_q)
            AL_IDLE: begin
               if (parity_error_i) begin
                  al_d = AL_PAR; // R02
                  al_cnt_d = 8'(PAR_CYC - 1);
               end else if (crc_error_i) begin
                  al_d = AL_CRC; // R01
                  al_cnt_d = 8'(CRC_CYC - 1);
               end
            end
            AL_CRC: begin
               if (parity_error_i) begin
                  al_d = AL_PAR; // R02
                  al_cnt_d = 8'(PAR_CYC - 1);
               end else if (al_cnt_q == 8'h00) begin
                  al_d = AL_IDLE; // R01
               end else begin
                  al_cnt_d = al_cnt_q - 8'h01;
               end
            end
            AL_PAR: begin
               if (al_cnt_q == 8'h00) begin
                  al_d = AL_IDLE; // R02
               end else begin
                  al_cnt_d = al_cnt_q - 8'h01;
               end
            end
            AL_TEST: begin
               al_d = AL_IDLE;
            end
         endcase
      end
      if (al_q == AL_TEST) begin
         tin_d = alert_n_i; // R03
      end
      oe_d = (al_d == AL_CRC) || (al_d == AL_PAR);
      alert_d = oe_d ? 1'b0 : dac_pkg::ALERT_IDLE; // R15
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         al_q <= AL_IDLE;
         al_cnt_q <= 8'h00;
         alert_q <= dac_pkg::ALERT_IDLE;
         oe_q <= 1'b0;
         tin_q <= 1'b1;
         tm_q <= 1'b0;
      end else begin
         al_q <= al_d;
         al_cnt_q <= al_cnt_d;
         alert_q <= alert_d;
         oe_q <= oe_d;
         tin_q <= tin_d;
         tm_q <= tm_d;
      end
   end

   assign alert_n_o = alert_q;
   assign alert_n_oe_o = oe_q;
   assign test_alert_o = tin_q;
   assign test_mode_o = tm_q;
   assign open_banks_o = open_q;
   assign beat_o = beat_q;
   assign core_xfer_o = core_q;
   assign misuse_o = misuse_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   crc_pulse_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R01
      $rose(alert_q) && $past(al_q) == AL_CRC && !$past(conn_test_enable_i) |->
      $past(alert_q, CRC_CYC + 1) && !$past(alert_q, CRC_CYC))
      else $error("CRC alert length wrong.");

   crc_low_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R01
      (al_q == AL_IDLE && crc_error_i && !conn_test_enable_i) |=> (!alert_q && oe_q))
      else $error("CRC alert not driven low.");

   par_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R02
      $rose(alert_q) && $past(al_q) == AL_PAR && !$past(conn_test_enable_i) |->
      $past(parity_error_i, PAR_CYC + 1) && !$past(alert_q, PAR_CYC))
      else $error("Parity alert released early.");

   test_release_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R03
      conn_test_enable_i |=> !oe_q && test_mode_o)
      else $error("Alert driven in test mode.");

   idle_high_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R15
      (al_q == AL_IDLE && !crc_error_i && !parity_error_i && !conn_test_enable_i) |=>
      (alert_q && !oe_q))
      else $error("Alert low while idle.");

   act_open_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R09
      req_i.cmd == dac_pkg::CMD_ACT |=> open_q[$past(sel)])
      else $error("Activate did not open bank.");

   burst_len_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R07
      (access && open_q[sel] && otf_enable_i && req_i.addr[dac_pkg::CHOP_BIT]) ##1
      !access [*8] |-> beat_q.valid ##1 !beat_q.valid)
      else $error("Full burst not eight beats.");

   chop_len_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R11
      (access && open_q[sel] && otf_enable_i && !req_i.addr[dac_pkg::CHOP_BIT]) ##1
      !access [*4] |-> beat_q.valid ##1 !beat_q.valid)
      else $error("Chopped burst not four beats.");

   core_four_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R06
      (access && open_q[sel]) ##1 !access [*4] |=> core_q)
      else $error("Core word not after four clocks.");

   pre_all_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R13
      (req_i.cmd == dac_pkg::CMD_PRE && req_i.addr[dac_pkg::PRE_BIT]) |=> open_q == '0)
      else $error("Precharge all left banks open.");

   miss_flag_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R08
      (access && !open_q[sel]) |=> misuse_q && !(beat_q.valid && beat_q.beat == 4'h0))
      else $error("Closed bank access not flagged.");

   crc_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) al_q == AL_CRC);
   par_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) al_q == AL_PAR);
   chop_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      beat_q.valid && left_q == dac_pkg::BEATS_CHOP && beat_q.beat == 4'h0);
   test_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) test_mode_o);

endmodule

// ==== rtl/dac_pkg.sv ====
// Package of constants and carrier types for the DRAM core access and alert block.
package dac_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int unsigned GROUPS = 2;
   localparam int unsigned BANKS_PER_GROUP = 4;
   localparam int unsigned BANKS = GROUPS * BANKS_PER_GROUP;
   localparam int unsigned ROW_W = 15;
   localparam int unsigned COL_W = 10;
   localparam int unsigned ADDR_W = 17;
   localparam int unsigned PRE_BIT = 10;
   localparam int unsigned CHOP_BIT = 12;

   // ----------------------------------------------------------------
   // Burst and timing counts
   // ----------------------------------------------------------------
   localparam logic [3:0] BEATS_FULL = 4'h8;
   localparam logic [3:0] BEATS_CHOP = 4'h4;
   localparam logic [2:0] CORE_CLOCKS = 3'h4;
   localparam int unsigned CRC_ALERT_CYC = 10;
   localparam int unsigned PAR_ALERT_CYC = 64;
   localparam logic ALERT_IDLE = 1'b1;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      CMD_NOP = 5'h01,
      CMD_ACT = 5'h02,
      CMD_RD = 5'h04,
      CMD_WR = 5'h08,
      CMD_PRE = 5'h10
   } dac_cmd_e;

   typedef struct packed {
      dac_cmd_e cmd;
      logic group_select;
      logic [1:0] bank_select;
      logic [ADDR_W-1:0] addr;
   } dac_req_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [2:0] bank;
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
      logic [3:0] beat;
      logic auto_pre;
   } dac_beat_s;

endpackage

// ==== bench/dac_ctrl_model.sv ====
// Controller model that places one command at a time on the command bus.
`timescale 1ns/100ps
module dac_ctrl_model (
   input wire logic clk_i,
   output dac_pkg::dac_req_s req_o
);
   // ----------------------------------------------------------------
   // Command driver
   // ----------------------------------------------------------------
   // The bus rests at no-operation until the bench, after reset, asks for traffic.
   initial begin
      req_o = '0;
      req_o.cmd = dac_pkg::CMD_NOP;
   end

   // Each command stands for one cycle; the bus then goes back to no-operation.
   // Accesses follow an activate of their bank unless a refusal is wanted.
   task automatic issue(input dac_pkg::dac_cmd_e c, input logic g, input logic [1:0] b,
                        input logic [16:0] a);
      @(posedge clk_i);
      req_o <= '{cmd: c, group_select: g, bank_select: b, addr: a};
      @(posedge clk_i);
      req_o.cmd <= dac_pkg::CMD_NOP;
   endtask
endmodule

// ==== bench/dac_core_tb.sv ====
// Self-checking testbench of the DRAM core access and alert block.
`timescale 1ns/100ps
module dac_core_tb;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic otf = 1'b1;
   logic chf = 1'b0;
   logic crc = 1'b0;
   logic par = 1'b0;
   logic conn_test_enable = 1'b0;
   logic ext = 1'b1;
   logic pin, al, oe, ta, tm, cx, mu;
   logic [7:0] ob;
   dac_pkg::dac_req_s req;
   dac_pkg::dac_beat_s bt;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;

   // The pin has a pull-up; either party may pull it low.
   assign pin = (oe ? al : 1'b1) & ext;
   always #50 clk_i = ~clk_i;

   dac_ctrl_model ctl (.clk_i(clk_i), .req_o(req));
   dac_core #(.CRC_CYC(3), .PAR_CYC(8)) dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .otf_enable_i(otf),
      .chop_fixed_i(chf), .crc_error_i(crc), .parity_error_i(par),
      .conn_test_enable_i(conn_test_enable), .alert_n_i(pin), .alert_n_o(al), .alert_n_oe_o(oe),
      .test_alert_o(ta), .test_mode_o(tm), .open_banks_o(ob), .beat_o(bt),
      .core_xfer_o(cx), .misuse_o(mu));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic print_verdict;
      if (n_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // A hang costs one mismatch; the whole run needs well under a thousand cycles.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic cy(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   function automatic logic [16:0] ca(input logic [9:0] c, input logic ap, input logic bc);
      ca = 17'h0_0000;
      ca[9:0] = c;
      ca[10] = ap;
      ca[12] = bc;
   endfunction

   task automatic burst(input logic w, input logic [2:0] bk, input logic [14:0] r,
                        input logic [9:0] c, input int n, input logic ap);
      logic [9:0] col;
      #1;
      for (int i = 0; i < n; i++) begin
         col = c + i[9:0];
         chk("valid", 1, bt.valid);
         chk("write", w, bt.write);
         chk("bank", bk, bt.bank);
         chk("row", r, bt.row);
         chk("col", col, bt.col);
         chk("beat", i, bt.beat);
         chk("auto_pre", ap, bt.auto_pre);
         chk("core_xfer", i == 4, cx);
         cy(1);
      end
      chk("burst_end", 0, bt.valid);
      chk("core_xfer", n == 4, cx);
   endtask

   task automatic hold(input int n, input logic inj);
      #1;
      for (int i = 0; i < n; i++) begin
         chk("alert_low", 0, al);
         chk("alert_oe", 1, oe);
         chk("pin", 0, pin);
         @(posedge clk_i);
         crc <= inj && (i == 2);
         #1;
      end
      chk("alert_high", 1, al);
      chk("alert_oe", 0, oe);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      cy(1);
      chk("alert", 1, al);
      chk("oe", 0, oe);
      chk("test_alert", 1, ta);
      chk("test_mode", 0, tm);
      chk("open", 0, ob);
   endtask

   // Full burst that wraps the column, then a chopped write with auto-precharge.
   task automatic t_access;
      ctl.issue(dac_pkg::CMD_ACT, 1'b1, 2'h2, 17'h0_5a5a);
      cy(0);
      chk("open", 8'h40, ob);
      ctl.issue(dac_pkg::CMD_RD, 1'b1, 2'h2, ca(10'h3fe, 1'b0, 1'b1));
      burst(1'b0, 3'h6, 15'h5a5a, 10'h3fe, 8, 1'b0);
      ctl.issue(dac_pkg::CMD_WR, 1'b1, 2'h2, ca(10'h010, 1'b1, 1'b0));
      burst(1'b1, 3'h6, 15'h5a5a, 10'h010, 4, 1'b1);
      chk("open", 8'h00, ob);
      ctl.issue(dac_pkg::CMD_RD, 1'b1, 2'h2, ca(10'h000, 1'b0, 1'b1));
      #1;
      chk("misuse", 1, mu);
      chk("valid", 0, bt.valid);
   endtask

   // Without on-the-fly selection the chop bit is ignored.
   task automatic t_fixed;
      @(posedge clk_i);
      otf <= 1'b0;
      chf <= 1'b1;
      ctl.issue(dac_pkg::CMD_ACT, 1'b0, 2'h1, 17'h0_0001);
      ctl.issue(dac_pkg::CMD_RD, 1'b0, 2'h1, ca(10'h020, 1'b0, 1'b1));
      burst(1'b0, 3'h1, 15'h0001, 10'h020, 4, 1'b0);
      @(posedge clk_i);
      chf <= 1'b0;
      ctl.issue(dac_pkg::CMD_WR, 1'b0, 2'h1, ca(10'h040, 1'b0, 1'b0));
      burst(1'b1, 3'h1, 15'h0001, 10'h040, 8, 1'b0);
   endtask

   task automatic t_pre;
      ctl.issue(dac_pkg::CMD_ACT, 1'b0, 2'h0, 17'h0_0002);
      ctl.issue(dac_pkg::CMD_ACT, 1'b1, 2'h1, 17'h0_0003);
      cy(0);
      chk("open", 8'h23, ob);
      ctl.issue(dac_pkg::CMD_PRE, 1'b0, 2'h0, ca(10'h000, 1'b0, 1'b0));
      cy(0);
      chk("open", 8'h22, ob);
      ctl.issue(dac_pkg::CMD_PRE, 1'b0, 2'h0, ca(10'h000, 1'b1, 1'b0));
      cy(0);
      chk("open", 8'h00, ob);
   endtask

   // A CRC error inside the parity hold must not stretch or restart it.
   task automatic t_alert;
      @(posedge clk_i);
      crc <= 1'b1;
      @(posedge clk_i);
      crc <= 1'b0;
      hold(3, 1'b0);
      @(posedge clk_i);
      par <= 1'b1;
      @(posedge clk_i);
      par <= 1'b0;
      hold(8, 1'b1);
   endtask

   task automatic t_test;
      @(posedge clk_i);
      conn_test_enable <= 1'b1;
      cy(2);
      chk("test_mode", 1, tm);
      @(posedge clk_i);
      ext <= 1'b0;
      crc <= 1'b1;
      @(posedge clk_i);
      crc <= 1'b0;
      cy(3);
      chk("test_alert", 0, ta);
      chk("oe", 0, oe);
      @(posedge clk_i);
      ext <= 1'b1;
      cy(3);
      chk("test_alert", 1, ta);
      @(posedge clk_i);
      conn_test_enable <= 1'b0;
      cy(3);
      chk("test_mode", 0, tm);
      chk("alert", 1, al);
   endtask

   initial begin
      repeat (10) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_access();
      t_fixed();
      t_pre();
      t_alert();
      t_test();
      print_verdict();
   end
endmodule
